/* deadband_gen.sv */
// deadband insertion for a complementary pwm pair
// assumes raw_level is registered in the same clock domain
`timescale 1ns/1ps
`include "tmr_defs.svh"
module deadband_gen (
  // clock and reset
  input wire logic   mclk,
  input wire logic   reset,
  // link to timer core
  deadband_if.stage  db
);
  import tmr_pkg::*;

  logic [7:0] gap_ff;
  logic       prev_ff;
  logic       pin_ff;
  logic       comp_ff;

  // every rising edge after a level change waits out the gap; falling edges act at once so the
  // other pin can never rise while this one is still high
  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_ff <= 1'b0;
      gap_ff  <= 8'h00;
      pin_ff  <= 1'b0;
      comp_ff <= 1'b0;
    end else if (!db.active) begin
      prev_ff <= db.raw_level;
      gap_ff  <= 8'h00;
      pin_ff  <= 1'b0;
      comp_ff <= 1'b0;
    end else begin
      prev_ff <= db.raw_level;
      if (db.raw_level != prev_ff) begin
        pin_ff  <= 1'b0;
        comp_ff <= 1'b0;
        gap_ff  <= db.delay_cycles;
      end else if (gap_ff != 8'h00) begin
        gap_ff <= gap_ff - 8'h01;
      end else begin
        pin_ff  <= db.raw_level;
        comp_ff <= ~db.raw_level;
      end
    end
  end

  assign db.out_pin  = pin_ff;
  assign db.out_comp = comp_ff;
endmodule

/* deadband_if.sv */
// carries the raw pwm level and the delayed pin pair between timer and deadband stage
`timescale 1ns/1ps
interface deadband_if;
  logic       raw_level;
  logic [7:0] delay_cycles;
  logic       active;
  logic       out_pin;
  logic       out_comp;
  modport core (output raw_level, output delay_cycles, output active,
                input out_pin, input out_comp);
  modport stage (input raw_level, input delay_cycles, input active,
                 output out_pin, output out_comp);
endinterface

/* test_timer_dual_pwm_capture_modes.sv */
// self-checking bench for the dual pwm / capture timer
// assumes the timer top, its bound checker and the pin source model
`timescale 1ns/1ps
`include "tmr_defs.svh"
module test_timer_dual_pwm_capture_modes;
  import tmr_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, level = 1'b0;
  logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'hE2068D4B;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, timer_in;
  logic        pwm_out, pwm_out_comp, comp_out, timer_irq;
  logic [1:0]  bresp, rresp, resp;
  int          miscompares = 0, n_compared = 0, cyc = 0, ha = 0, hb = 0, bl = 0, irqs = 0;

  always #20 mclk = ~mclk;

  tmr_dual_pwm_capture i_tmr_dual_pwm_capture (.mclk(mclk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_in(timer_in), .pwm_out(pwm_out), .pwm_out_comp(pwm_out_comp),
    .comp_pin_is_output(comp_out), .timer_irq(timer_irq));
  timer_pin_source i_timer_pin_source (.mclk(mclk), .level(level),
    .pin_is_output(comp_out), .timer_in(timer_in));

  // free-running tallies; scenarios work on differences so nothing is cleared
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ha <= ha + pwm_out;
    hb <= hb + pwm_out_comp;
    bl <= bl + (!pwm_out && !pwm_out_comp);
    irqs <= irqs + timer_irq;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // primary minus complement high time over two periods
  function automatic logic [31:0] pwm_skew(input logic pol, input int p, input int r);
    return pol ? 4 * p - 2 * r : 2 * r - 4 * p;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // flags sampled at the falling edge so the taking edge is never raced
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] idx);
    logic ta, tr;
    @(posedge mclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rv = rdata;
      resp = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask

  // disable, set up, then enable last
  task automatic cfg(input tmr_mode_t m, input logic pol, input logic [1:0] isrc,
                     input logic [15:0] start, input logic [15:0] rel,
                     input logic [15:0] val, input logic [7:0] db);
    wr(`OFS_CTL0, {28'h0, m, pol, 1'b0});
    wr(`OFS_CTL1, {29'h0, isrc, m != mode_capture});
    wr(`OFS_COUNT, {16'h0, start});
    wr(`OFS_PWMCAP, {16'h0, val});
    wr(`OFS_DEADBAND, {24'h0, db});
    wr(`OFS_RELOAD, {16'h0, rel});
    wr(`OFS_CTL0, {28'h0, m, pol, 1'b1});
  endtask

  // limit is several times the expected run length
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    end_sim;
  end

  initial begin
    int d, p, r, db, a0, b0, c0, i0, l0;
    logic [31:0] ca;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(`OFS_RELOAD);
    chk(rv, {16'h0, `RELOAD_RESET});
    rd(`OFS_COUNT);
    chk(rv, {16'h0, `CNT_RESET});
    rd(4'h7);
    chk(resp, `RESP_SLVERR);
    wr(4'h9, 32'h1);
    chk(resp, `RESP_SLVERR);
    wr(`OFS_DEADBAND, 32'hC8);
    rd(`OFS_DEADBAND);
    chk(rv, {24'h0, `DB_MAX});
    // pwm mode field without the extension bit stays idle
    wr(`OFS_CTL0, 32'h4);
    chk(comp_out, 1'b0);
    // restart captures: edges of both kinds, every interrupt source choice
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d = 4 + seed % 40;
      cfg(mode_capture_restart, k[0], k[1:0], 16'h1, 16'hFFFF, 16'h0, 8'h0);
      chk(comp_out, 1'b0);
      i0 = irqs;
      repeat (4) begin
        repeat (d) @(posedge mclk);
        level <= ~level;
      end
      repeat (6) @(posedge mclk);
      chk(irqs - i0, (k == 2) ? 0 : 2);
      rd(`OFS_PWMCAP);
      chk(rv, 2 * d);
      rd(`OFS_CTL1);
      chk(rv[`CTL1_CAUSE_BIT], 1'b1);
    end
    // reload with no capture: plain capture runs on, restart wraps to one
    for (int k = 0; k < 2; k++) begin
      i0 = irqs;
      cfg(tmr_mode_t'(2 * k), 1'b0, 2'h0, 16'h1, 16'h14, 16'h0, 8'h0);
      repeat (80) @(posedge mclk);
      wr(`OFS_CTL0, {28'h0, tmr_mode_t'(2 * k), 2'h0});
      rd(`OFS_COUNT);
      ca = rv;
      repeat (5) @(posedge mclk);
      rd(`OFS_COUNT);
      chk(rv, ca);
      chk(ca > 32'h14, k == 0);
      chk(k ? (irqs - i0 > 2) : irqs - i0, 1);
      rd(`OFS_CTL1);
      chk(rv[`CTL1_CAUSE_BIT], 1'b0);
      // a reload-only interrupt leaves the cleared capture value untouched
      rd(`OFS_PWMCAP);
      chk(rv, 32'h0);
    end
    // dual pwm, both polarities, random match, period and deadband
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      p = 24 + seed[5:0];
      r = p + 24 + seed[11:6];
      db = (k == 0) ? 0 : seed[16:12] % 19;
      cfg(mode_pwm_dual, k[0], 2'h0, 16'(1 + seed[18:17]), 16'(r), 16'(p), 8'(db));
      chk(comp_out, 1'b1);
      repeat (2) @(posedge pwm_out);
      @(negedge mclk);
      c0 = cyc;
      a0 = ha;
      b0 = hb;
      l0 = bl;
      i0 = irqs;
      repeat (2) @(posedge pwm_out);
      @(negedge mclk);
      chk(cyc - c0, 2 * r);
      chk((ha - a0) - (hb - b0), pwm_skew(k[0], p, r));
      chk(bl - l0, 4 * (db + 1));
      chk(irqs - i0, 2);
    end
    end_sim;
  end
endmodule

/* timer_pin_source.sv */
// signal source on the shared timer pin, yielding when the pin turns output
// assumes the bench sets the wanted level just after a rising edge
`timescale 1ns/1ps
module timer_pin_source (
  // clock
  input wire logic mclk,
  // commanded level and pin direction
  input wire logic level,
  input wire logic pin_is_output,
  // line toward the timer
  output logic     timer_in
);
  initial timer_in = 1'b0;
  // a released line has no level; toggling keeps a stale value from passing
  always @(posedge mclk) begin
    timer_in <= pin_is_output ? ~timer_in : level;
  end
endmodule

/* tmr_defs.svh */
// register offsets, field positions and constants for the dual pwm / capture timer
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define OFS_CTL0        4'h0
`define OFS_CTL1        4'h1
`define OFS_COUNT       4'h2
`define OFS_RELOAD      4'h3
`define OFS_PWMCAP      4'h4
`define OFS_DEADBAND    4'h5
`define OFS_STATUS      4'h6

// control zero fields
`define CTL0_EN_BIT     0
`define CTL0_POL_BIT    1
`define CTL0_MODE_LSB   2
`define CTL0_PRE_LSB    4
// control one fields
`define CTL1_MODEX_BIT  0
`define CTL1_ISRC_LSB   1
`define CTL1_CAUSE_BIT  3

`define CNT_RESTART     16'h0001
`define CNT_RESET       16'h0001
`define RELOAD_RESET    16'hFFFF
`define DB_MAX          8'h80
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* tmr_dual_pwm_capture.sv */
// 16-bit timer: dual complementary pwm with deadband, capture, capture-restart
// assumes an axi4-lite master, synchronous timer input, one clock domain
//
// Functional notes
// - dual pwm drives output and complement
// - count to match, then toggle output
// - at reload: interrupt, count to 0001H
// - polarity one: high, low at match
// - polarity zero: low, high at match
// - second pin is inverse of primary
// - rising edges delayed by 1..129 cycles
// - dual pwm turns input pin into output
// - extension bit needed for two modes
// - written start count affects first pass
// - capture copies count on chosen edge
// - capture: interrupt, set cause, keep counting
// - capture reload: interrupt, clear cause, no reload
// - restart capture: store, interrupt, count to 0001H
// - restart reload: interrupt, reload, clear cause
// - interrupt source select limits event types
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_dual_pwm_capture #(
  parameter int CNT_W = 16,
  parameter int PRE_W = 3
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // axi4-lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer pins
  input  wire logic        timer_in,
  output logic             pwm_out,
  output logic             pwm_out_comp,
  output logic             comp_pin_is_output,
  output logic             timer_irq
);
  import tmr_pkg::*;

  // software-visible state, then internal pwm level, input edge, prescaler and interrupt flops
  logic             en_ff;
  logic             pol_ff;
  logic [1:0]       mode_ff;
  logic [PRE_W-1:0] pre_ff;
  logic             modex_ff;
  logic [1:0]       isrc_ff;
  logic             cause_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] reload_ff;
  logic [CNT_W-1:0] pwmcap_ff;
  logic [7:0]       deadband_ff;
  logic             level_ff;
  logic             in_prev_ff;
  logic [6:0]       pre_cnt_ff;
  logic             irq_ff;

  // bus handshake state
  logic             aw_got_ff;
  logic             w_got_ff;
  logic [5:0]       awaddr_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;

  tmr_mode_t        mode;
  logic             tick;
  logic             cap_edge;
  logic             at_reload;
  logic             at_match;
  logic             wr_fire;
  logic [3:0]       wr_idx;
  logic [3:0]       rd_idx;
  logic [6:0]       pre_limit;
  logic             cap_evt;
  logic             rel_evt;

  deadband_if db ();

  // mode resolves from the two-bit field and the extension bit; the
  // extension bit is what separates dual pwm and restart from idle
  always_comb begin
    unique case ({modex_ff, mode_ff})
      3'b000:  mode = mode_capture;
      3'b101:  mode = mode_pwm_dual;
      3'b110:  mode = mode_capture_restart;
      default: mode = mode_idle;
    endcase
  end

  // prescaler divides by 2^pre; counter steps only on its tick
  assign pre_limit = 7'((1 << pre_ff) - 1);
  assign tick      = en_ff && (pre_cnt_ff == pre_limit);
  assign at_reload = tick && (count_ff == reload_ff);
  assign at_match  = tick && (count_ff == pwmcap_ff);
  // chosen input edge, ignored in dual pwm because the pin is an output then
  assign cap_edge  = en_ff && (mode != mode_pwm_dual) &&
                     (pol_ff ? (timer_in && !in_prev_ff)
                             : (!timer_in && in_prev_ff));
  assign cap_evt   = cap_edge && (mode == mode_capture || mode == mode_capture_restart);
  assign rel_evt   = at_reload && (mode != mode_idle);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_cnt_ff <= 7'h00;
    end else if (!en_ff || tick) begin
      pre_cnt_ff <= 7'h00;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      in_prev_ff <= 1'b0;
    end else begin
      in_prev_ff <= timer_in;
    end
  end

  // write decode shared by register processes
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_idx  = awaddr_ff[5:2];

  // counter: software write wins only while disabled; restart value after
  // each reload outside plain capture means a written start applies to the first pass only
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_ff <= `CNT_RESET;
    end else if (wr_fire && wr_idx == `OFS_COUNT && !en_ff) begin
      count_ff <= wdata_ff[CNT_W-1:0];
    end else if (cap_evt && mode == mode_capture_restart) begin
      count_ff <= `CNT_RESTART;
    end else if (rel_evt && mode != mode_capture) begin
      count_ff <= `CNT_RESTART;
    end else if (tick) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // capture value register doubles as pwm match
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwmcap_ff <= 16'h0000;
    end else if (cap_evt) begin
      pwmcap_ff <= count_ff;
    end else if (wr_fire && wr_idx == `OFS_PWMCAP) begin
      pwmcap_ff <= wdata_ff[CNT_W-1:0];
    end
  end

  // cause flag: capture sets, reload clears outside dual pwm; a capture in the reload
  // cycle wins so the capture is not lost
  always_ff @(posedge mclk) begin
    if (reset) begin
      cause_ff <= 1'b0;
    end else if (cap_evt) begin
      cause_ff <= 1'b1;
    end else if (rel_evt && mode != mode_pwm_dual) begin
      cause_ff <= 1'b0;
    end
  end

  // one-cycle interrupt pulse, filtered by source select in capture modes
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else if (mode == mode_pwm_dual) begin
      irq_ff <= rel_evt;
    end else begin
      irq_ff <= (cap_evt && isrc_ff != isrc_reload_only) ||
                (rel_evt && isrc_ff != isrc_capture_only);
    end
  end

  // primary pwm level: idle level while disabled, flips at match, back at reload
  always_ff @(posedge mclk) begin
    if (reset) begin
      level_ff <= 1'b0;
    end else if (!en_ff || mode != mode_pwm_dual) begin
      level_ff <= pol_ff;
    end else if (at_reload) begin
      level_ff <= pol_ff;
    end else if (at_match) begin
      level_ff <= ~pol_ff;
    end
  end

  assign db.raw_level    = level_ff;
  assign db.delay_cycles = deadband_ff;
  assign db.active       = en_ff && (mode == mode_pwm_dual);

  deadband_gen u_deadband (
    .mclk  (mclk),
    .reset (reset),
    .db    (db)
  );

  assign pwm_out            = db.out_pin;
  assign pwm_out_comp       = db.out_comp;
  assign comp_pin_is_output = (mode == mode_pwm_dual);
  assign timer_irq          = irq_ff;

  // control and period registers; deadband saturates at its maximum
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_ff       <= 1'b0;
      pol_ff      <= 1'b0;
      mode_ff     <= 2'h0;
      pre_ff      <= '0;
      modex_ff    <= 1'b0;
      isrc_ff     <= 2'h0;
      reload_ff   <= `RELOAD_RESET;
      deadband_ff <= 8'h00;
    end else if (wr_fire) begin
      unique case (wr_idx)
        `OFS_CTL0: begin
          en_ff   <= wdata_ff[`CTL0_EN_BIT];
          pol_ff  <= wdata_ff[`CTL0_POL_BIT];
          mode_ff <= wdata_ff[`CTL0_MODE_LSB +: 2];
          pre_ff  <= wdata_ff[`CTL0_PRE_LSB +: PRE_W];
        end
        `OFS_CTL1: begin
          modex_ff <= wdata_ff[`CTL1_MODEX_BIT];
          isrc_ff  <= wdata_ff[`CTL1_ISRC_LSB +: 2];
        end
        `OFS_RELOAD: begin
          reload_ff <= wdata_ff[CNT_W-1:0];
        end
        `OFS_DEADBAND: begin
          deadband_ff <= (wdata_ff[7:0] > `DB_MAX) ? `DB_MAX : wdata_ff[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // write channel: address and data taken independently, response after both
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_idx > `OFS_DEADBAND) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // read channel: data registered one cycle after address accepted
  assign rd_idx = s_axi_araddr[5:2];

  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      unique case (rd_idx)
        `OFS_CTL0: begin
          rdata_ff[`CTL0_EN_BIT]              <= en_ff;
          rdata_ff[`CTL0_POL_BIT]             <= pol_ff;
          rdata_ff[`CTL0_MODE_LSB +: 2]       <= mode_ff;
          rdata_ff[`CTL0_PRE_LSB +: PRE_W]    <= pre_ff;
        end
        `OFS_CTL1: begin
          rdata_ff[`CTL1_MODEX_BIT]           <= modex_ff;
          rdata_ff[`CTL1_ISRC_LSB +: 2]       <= isrc_ff;
          rdata_ff[`CTL1_CAUSE_BIT]           <= cause_ff;
        end
        `OFS_COUNT:    rdata_ff[CNT_W-1:0] <= count_ff;
        `OFS_RELOAD:   rdata_ff[CNT_W-1:0] <= reload_ff;
        `OFS_PWMCAP:   rdata_ff[CNT_W-1:0] <= pwmcap_ff;
        `OFS_DEADBAND: rdata_ff[7:0]       <= deadband_ff;
        `OFS_STATUS:   rdata_ff[2:0]       <= {cause_ff, pwm_out_comp, pwm_out};
        default:       rresp_ff <= `RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
endmodule

/* tmr_dual_pwm_capture_monitor.sv */
// assertions on the timer pins and the register bus handshakes
// assumes it is bound to the timer top; one clock, synchronous reset
`timescale 1ns/1ps
module tmr_dual_pwm_capture_monitor #(
  parameter int CNT_W = 16,
  parameter int PRE_W = 3
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // timer pins
  input wire logic        pwm_out,
  input wire logic        pwm_out_comp,
  input wire logic        comp_pin_is_output
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // address and data taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_up;
    s_axi_bvalid;
  endsequence

  AST_PIN_IDLE:
    assert property (!comp_pin_is_output |-> !pwm_out && !pwm_out_comp)
    else $error("pwm pins active outside dual pwm");
  AST_NO_OVERLAP:
    assert property (!(pwm_out && pwm_out_comp))
    else $error("both pwm pins high together");
  AST_GAP_MAIN:
    assert property ($rose(pwm_out) |-> !$past(pwm_out_comp))
    else $error("primary rose with no gap");
  AST_GAP_COMP:
    assert property ($rose(pwm_out_comp) |-> !$past(pwm_out))
    else $error("complement rose with no gap");
  AST_B_AFTER_WR:
    assert property (s_wr_taken |-> ##2 s_resp_up)
    else $error("write response late");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_AFTER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule

bind tmr_dual_pwm_capture tmr_dual_pwm_capture_monitor #(.CNT_W(CNT_W), .PRE_W(PRE_W)) i_mon (
  .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pwm_out(pwm_out), .pwm_out_comp(pwm_out_comp),
  .comp_pin_is_output(comp_pin_is_output));

/* tmr_pkg.sv */
// types shared by the timer core and its deadband stage
package tmr_pkg;
  typedef enum logic [1:0] {
    mode_capture,
    mode_pwm_dual,
    mode_capture_restart,
    mode_idle
  } tmr_mode_t;

  // interrupt source select encodings
  typedef enum logic [1:0] {
    isrc_both,
    isrc_capture_only,
    isrc_reload_only,
    isrc_both_alt
  } isrc_t;
endpackage
